// >>> logic/prmc_recorder_menu.sv
// prmc_recorder_menu: stage recorders, menu, settings and APB registers
// assumes stage signals on the system clock, raw button and blocking pins
// Function
// - new start clears and restarts duration percent
// - five-deep duration stack, oldest dropped
// - trip records duration as 100 percent
// - start counter per stage, 0 to 255
// - view 0 last digit shows blocking input
// - blocking acts per switchgroup bits
// - view 0 enters test mode, outputs one-by-one
// - node address zero without serial use
// - traffic monitor zero when communicating, else rolls
// - remote setting writes need password first
// - bank selector picks main or second settings
// - dark after last view, step restarts
// - step plus program clears recorded values
// - supply restart clears recorded values
// - address, rate, password, bank kept non-volatile
// - step long forward, short back, hold scans
// - program 1 s enters submenu on release
// - program 5 s in view A, except on the monitor, toggles setting mode
// - setting: step increments digit, program moves cursor
// - setting: both buttons store edited value
// - outside setting: both clear and release latches
// - program releases latches only when dark
`timescale 1ns/100ps
module prmc_recorder_menu #(
  parameter int STEP_FWD = prmc_pkg::STEP_FWD_CYC,
  parameter int SCAN_START = prmc_pkg::SCAN_START_CYC,
  parameter int SCAN_REP = prmc_pkg::SCAN_REP_CYC,
  parameter int PROG_SUB = prmc_pkg::PROG_SUB_CYC,
  parameter int PROG_SET = prmc_pkg::PROG_SET_CYC,
  parameter int TICK = prmc_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_btn,
  input wire logic prog_btn,
  input wire logic blocking_input,
  input wire logic [1:0] stage_start,
  input wire logic [1:0] stage_trip,
  input wire logic serial_used,
  input wire logic comm_active,
  input wire prmc_pkg::prmc_nv_t nv_load,
  output prmc_pkg::prmc_nv_t nv_cfg,
  output logic [1:0] stage_block,
  output logic [1:0][15:0] op_time,
  output logic bank_sel,
  output logic [3:0] test_out,
  output logic latch_release,
  output logic setting_mode,
  output prmc_pkg::prmc_disp_t disp
);
  localparam int TW = prmc_pkg::TICK_W;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK - 1);

  prmc_pkg::prmc_st_t r;
  prmc_pkg::prmc_st_t n;
  logic step_lvl;
  logic prog_lvl;
  logic s_sh;
  logic s_md;
  logic s_rp;
  logic p_sh;
  logic p_md;
  logic p_hi;
  logic both;
  logic cb_rise;
  logic clr;
  logic [1:0] rise;
  logic [1:0][15:0] opt_sel;

  function automatic logic [2:0] nsub(input prmc_pkg::prmc_view_t v);
    if (v == prmc_pkg::V_8 || v == prmc_pkg::V_9) begin
      nsub = 3'h1;
    end else if (v == prmc_pkg::V_A) begin
      nsub = 3'h4;
    end else begin
      nsub = 3'h0;
    end
  endfunction

  function automatic logic [3:0] vdig(input prmc_pkg::prmc_view_t v);
    vdig = 4'hF;
    for (int i = 0; i < 12; i++) begin
      if (v[i]) begin
        vdig = prmc_pkg::VIEW_DIGIT[i];
      end
    end
  endfunction

  prmc_button #(.T_MID(STEP_FWD), .T_HOLD(SCAN_START), .T_REP(SCAN_REP)) u_step (
    .clk(clk),
    .reset_n(reset_n),
    .btn_pin(step_btn),
    .abort(both),
    .level(step_lvl),
    .ev_short(s_sh),
    .ev_mid(s_md),
    .ev_hold(),
    .ev_rep(s_rp)
  );

  prmc_button #(.T_MID(PROG_SUB), .T_HOLD(PROG_SET), .T_REP(PROG_SET)) u_prog (
    .clk(clk),
    .reset_n(reset_n),
    .btn_pin(prog_btn),
    .abort(both),
    .level(prog_lvl),
    .ev_short(p_sh),
    .ev_mid(p_md),
    .ev_hold(p_hi),
    .ev_rep()
  );

  assign both = step_lvl & prog_lvl;
  assign cb_rise = both & !r.both;
  assign clr = cb_rise & !r.setm;
  assign rise = stage_start & ~r.prv;
  assign opt_sel[0] = r.nv.bank ? r.opt[2] : r.opt[0];
  assign opt_sel[1] = r.nv.bank ? r.opt[3] : r.opt[1];

  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic prot;
    logic wr;
    rd = '0;
    hit = 1'b0;
    prot = 1'b0;
    wr = psel && penable && pwrite && !r.slverr;
    n = r;
    n.tick = 1'b0;
    n.rel = 1'b0;
    n.both = both;
    n.prv = stage_start;
    n.bsy = {r.bsy[1:0], blocking_input};
    if (r.bsy[2] == r.bsy[1]) begin
      n.blk = r.bsy[1];
    end
    if (r.tdiv == TICK_LAST) begin
      n.tdiv = '0;
      n.tick = 1'b1;
    end else begin
      n.tdiv = r.tdiv + 1'b1;
    end
    if (comm_active) begin
      n.mon = 8'h00;
    end else if (r.tick) begin
      n.mon = r.mon + 8'h01;
    end

    // duration recorders: the stack head is the live counter
    for (int s = 0; s < 2; s++) begin
      if (rise[s]) begin
        n.stk[s] = {r.stk[s][3:0], 8'h00};
        n.pre[s] = 16'h0000;
        n.act[s] = 1'b1;
        if (r.scnt[s] != prmc_pkg::CNT_MAX) begin
          n.scnt[s] = r.scnt[s] + 8'h01;
        end
      end else if (r.act[s] && stage_trip[s]) begin
        n.stk[s][0] = prmc_pkg::PCT_TRIP;
        n.act[s] = 1'b0;
      end else if (r.act[s] && !stage_start[s]) begin
        n.act[s] = 1'b0;
      end else if (r.act[s] && r.tick) begin
        // op time is in 10 ms units, so one percent is that many ticks
        if (r.pre[s] + 16'h0001 >= opt_sel[s]) begin
          n.pre[s] = 16'h0000;
          if (r.stk[s][0] < prmc_pkg::PCT_MAX) begin
            n.stk[s][0] = r.stk[s][0] + 8'h01;
          end
        end else begin
          n.pre[s] = r.pre[s] + 16'h0001;
        end
      end
    end

    if (r.testm) begin
      if (s_sh || s_md) begin
        n.tidx = r.tidx + 2'h1;
        if (r.tidx == 2'h3) begin
          n.testm = 1'b0;
        end
      end
      if (p_md || p_hi) begin
        n.testm = 1'b0;
      end
    end else if (r.setm) begin
      if (s_sh || s_md) begin
        if (r.cur) begin
          n.edit[7:4] = r.edit[7:4] + 4'h1;
        end else begin
          n.edit[3:0] = r.edit[3:0] + 4'h1;
        end
      end
      if (p_md) begin
        n.cur = !r.cur;
      end
      if (p_hi) begin
        n.setm = 1'b0;
      end
      if (cb_rise) begin
        n.setm = 1'b0;
        case (r.sub)
          3'h0: n.nv.addr = serial_used ? r.edit : 8'h00;
          3'h1: n.nv.rate = r.edit[2:0];
          3'h3: n.nv.pass = r.edit;
          3'h4: n.nv.bank = r.edit[0];
          default: n.nv = r.nv;
        endcase
      end
    end else if (r.view == prmc_pkg::V_DARK) begin
      if (s_sh || s_md || s_rp) begin
        n.view = prmc_pkg::V_1;
      end
      if (p_sh || p_md) begin
        n.rel = 1'b1;
      end
    end else if (s_md || (s_rp && r.sub == 3'h0)) begin
      if (r.sub != 3'h0) begin
        n.sub = (r.sub == nsub(r.view)) ? 3'h0 : r.sub + 3'h1;
      end else begin
        n.view = prmc_pkg::prmc_view_t'({r.view[10:0], r.view[11]});
      end
    end else if (s_sh) begin
      if (r.sub != 3'h0) begin
        n.sub = r.sub - 3'h1;
      end else begin
        n.view = prmc_pkg::prmc_view_t'({r.view[0], r.view[11:1]});
      end
    end else if (p_md && r.sub == 3'h0) begin
      if (r.view == prmc_pkg::V_0) begin
        n.testm = 1'b1;
        n.tidx = 2'h0;
      end else begin
        n.sub = nsub(r.view) == 3'h0 ? 3'h0 : 3'h1;
      end
    end else if (p_hi && r.view == prmc_pkg::V_A && r.sub != 3'h2) begin
      n.setm = 1'b1;
      n.edit = r.disp.val;
      n.cur = 1'b0;
    end

    if (clr) begin
      n.stk = '0;
      n.scnt = '0;
      n.act = 2'h0;
      n.rel = 1'b1;
    end

    // register decode in the setup phase, answered with no wait state
    case (paddr)
      prmc_pkg::A_STATUS: rd = {24'h0, vdig(r.view), r.unlock, r.setm, r.testm, r.blk};
      prmc_pkg::A_SGB: rd = {30'h0, r.blocking_switchgroup};
      prmc_pkg::A_COMM: rd = {15'h0, r.nv.bank, 5'h0, r.nv.rate, r.nv.addr};
      prmc_pkg::A_PASS: rd = {31'h0, r.unlock};
      prmc_pkg::A_CNT: rd = {16'h0, r.scnt[1], r.scnt[0]};
      prmc_pkg::A_MON: rd = {24'h0, r.mon};
      default: rd = '0;
    endcase
    hit = paddr == prmc_pkg::A_STATUS || paddr == prmc_pkg::A_SGB || paddr == prmc_pkg::A_COMM ||
      paddr == prmc_pkg::A_PASS || paddr == prmc_pkg::A_CNT || paddr == prmc_pkg::A_MON;
    prot = paddr == prmc_pkg::A_SGB || paddr == prmc_pkg::A_COMM;
    for (int i = 0; i < 4; i++) begin
      if (paddr == 8'(prmc_pkg::A_OPT + 4 * i)) begin
        rd = {16'h0, r.opt[i]};
        hit = 1'b1;
        prot = 1'b1;
        if (wr) begin
          n.opt[i] = pwdata[15:0];
        end
      end
    end
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 5; e++) begin
        if (paddr == 8'(prmc_pkg::A_STK + 4 * (5 * s + e))) begin
          rd = {24'h0, r.stk[s][e]};
          hit = 1'b1;
        end
      end
    end
    if (psel && !penable) begin
      n.rdata = rd;
      n.slverr = !hit || (pwrite && prot && !r.unlock);
    end
    if (wr && paddr == prmc_pkg::A_SGB) begin
      n.blocking_switchgroup = pwdata[1:0];
    end
    if (wr && paddr == prmc_pkg::A_COMM) begin
      n.nv.addr = serial_used ? pwdata[7:0] : 8'h00;
      n.nv.rate = pwdata[prmc_pkg::COMM_RATE_LSB +: 3];
      n.nv.bank = pwdata[prmc_pkg::COMM_BANK_BIT];
    end
    if (wr && paddr == prmc_pkg::A_PASS) begin
      n.unlock = (pwdata[7:0] == r.nv.pass);
    end

    n.disp.on = (r.view != prmc_pkg::V_DARK);
    n.disp.adr = vdig(r.view);
    case (r.view)
      prmc_pkg::V_0: n.disp.val = {7'h0, r.blk};
      prmc_pkg::V_8: n.disp.val = r.sub == 3'h0 ? r.stk[0][0] : r.scnt[0];
      prmc_pkg::V_9: n.disp.val = r.sub == 3'h0 ? r.stk[1][0] : r.scnt[1];
      prmc_pkg::V_A: begin
        case (r.sub)
          3'h1: n.disp.val = {5'h0, r.nv.rate};
          3'h2: n.disp.val = r.mon;
          3'h3: n.disp.val = r.nv.pass;
          3'h4: n.disp.val = {7'h0, r.nv.bank};
          default: n.disp.val = r.nv.addr;
        endcase
      end
      default: n.disp.val = 8'h00;
    endcase
    if (r.setm) begin
      n.disp.val = r.edit;
    end
    if (r.testm) begin
      n.disp.val = {6'h0, r.tidx};
    end

    if (!reset_n) begin
      n = '0;
      n.view = prmc_pkg::V_1;
      n.blocking_switchgroup = prmc_pkg::SGB_RST;
      n.opt = {4{prmc_pkg::OPT_RST}};
      n.nv = nv_load;
    end
    // applied after the reset load too, so the address never shows nonzero unused
    if (!serial_used) begin
      n.nv.addr = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign pready = 1'b1;
  assign prdata = r.rdata;
  assign pslverr = r.slverr;
  assign stage_block = r.blocking_switchgroup & {2{r.blk}};
  assign op_time = opt_sel;
  assign bank_sel = r.nv.bank;
  assign nv_cfg = r.nv;
  assign test_out = r.testm ? (4'h1 << r.tidx) : 4'h0;
  assign latch_release = r.rel;
  assign setting_mode = r.setm;
  assign disp = r.disp;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence low_rise_s;
    rise[0] && !clr;
  endsequence
  sequence trip_s;
    r.act[0] && stage_trip[0] && !rise[0] && !clr;
  endsequence
  sequence pin_steady_s;
    blocking_input [*5];
  endsequence
  sequence idle_menu_s;
    !r.setm && !r.testm;
  endsequence

  start_clear_a: assert property (low_rise_s |=> r.stk[0][0] == 8'h00 && r.act[0])
    else $error("duration not restarted on start");
  stack_push_a: assert property (low_rise_s |=> r.stk[0][4:1] == $past(r.stk[0][3:0]))
    else $error("stack not pushed on start");
  trip_full_a: assert property (trip_s |=> r.stk[0][0] == 8'h64 && !r.act[0])
    else $error("trip not recorded as 100");
  start_count_a: assert property (rise[1] && !clr && r.scnt[1] != 8'hFF
    |=> r.scnt[1] == $past(r.scnt[1]) + 8'h01)
    else $error("start count not incremented");
  block_digit_a: assert property (idle_menu_s ##0 r.view == prmc_pkg::V_0
    |=> r.disp.val == {7'h0, $past(r.blk)})
    else $error("blocking digit wrong");
  block_apply_a: assert property (pin_steady_s |-> ##1 stage_block[0] == r.blocking_switchgroup[0])
    else $error("blocking not applied");
  addr_zero_a: assert property (!serial_used |=> r.nv.addr == 8'h00)
    else $error("address nonzero without serial");
  mon_zero_a: assert property (comm_active |=> r.mon == 8'h00)
    else $error("traffic monitor not zero");
  lock_reject_a: assert property (psel && penable && pwrite && paddr == prmc_pkg::A_SGB && !r.unlock
    |-> pslverr ##1 $stable(r.blocking_switchgroup))
    else $error("locked write accepted");
  dark_step_a: assert property (idle_menu_s ##0 r.view == prmc_pkg::V_DARK && (s_sh || s_md)
    |=> r.view == prmc_pkg::V_1)
    else $error("dark step did not restart");
  combo_clear_a: assert property (clr |=> r.scnt == 16'h0000 && latch_release)
    else $error("combo did not clear");
  dark_rel_a: assert property (idle_menu_s ##0 r.view == prmc_pkg::V_DARK && p_sh
    |=> latch_release ##1 !latch_release)
    else $error("dark program press no release");
  set_exit_a: assert property (r.setm && p_hi |=> !setting_mode)
    else $error("setting mode not left");
  test_onehot_a: assert property (r.testm |-> $onehot(test_out))
    else $error("test outputs not one at a time");
endmodule

// >>> logic/prmc_pkg.sv
// prmc_pkg: constants, carriers and state types of the recorder/menu block
// assumes one 20 MHz system clock shared by every user of the package
package prmc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STEP_FWD_MS = 500;
  localparam int STEP_FWD_CYC = STEP_FWD_MS * CYC_PER_MS;
  localparam int SCAN_START_MS = 1000;
  localparam int SCAN_START_CYC = SCAN_START_MS * CYC_PER_MS;
  localparam int SCAN_REP_MS = 200;
  localparam int SCAN_REP_CYC = SCAN_REP_MS * CYC_PER_MS;
  localparam int PROG_SUB_MS = 1000;
  localparam int PROG_SUB_CYC = PROG_SUB_MS * CYC_PER_MS;
  localparam int PROG_SET_MS = 5000;
  localparam int PROG_SET_CYC = PROG_SET_MS * CYC_PER_MS;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W = 11;
  localparam int BTN_CW = 28;

  localparam logic [7:0] PCT_TRIP = 8'h64;
  localparam logic [7:0] PCT_MAX = 8'h63;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [1:0] SGB_RST = 2'h0;
  localparam logic [15:0] OPT_RST = 16'h0064;

  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_SGB = 8'h04;
  localparam logic [7:0] A_OPT = 8'h08;
  localparam logic [7:0] A_COMM = 8'h18;
  localparam logic [7:0] A_PASS = 8'h1C;
  localparam logic [7:0] A_STK = 8'h20;
  localparam logic [7:0] A_CNT = 8'h48;
  localparam logic [7:0] A_MON = 8'h4C;
  localparam int COMM_RATE_LSB = 8;
  localparam int COMM_BANK_BIT = 16;

  // views in display order, so stepping is a rotation
  typedef enum logic [11:0] {
    V_1 = 12'h001, V_2 = 12'h002, V_3 = 12'h004, V_4 = 12'h008,
    V_5 = 12'h010, V_6 = 12'h020, V_7 = 12'h040, V_8 = 12'h080,
    V_9 = 12'h100, V_0 = 12'h200, V_A = 12'h400, V_DARK = 12'h800
  } prmc_view_t;
  localparam logic [11:0][3:0] VIEW_DIGIT = {4'hF, 4'hA, 4'h0, 4'h9, 4'h8, 4'h7,
    4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] rate;
    logic [7:0] pass;
    logic bank;
  } prmc_nv_t;

  typedef struct packed {
    logic on;
    logic [3:0] adr;
    logic [7:0] val;
  } prmc_disp_t;

  typedef struct packed {
    logic [2:0] sy;
    logic lvl;
    logic [BTN_CW-1:0] cnt;
    logic p2;
    logic ab;
    logic sh;
    logic md;
    logic hi;
    logic rp;
  } prmc_btn_t;

  typedef struct packed {
    prmc_view_t view;
    logic [2:0] sub;
    logic setm;
    logic testm;
    logic [1:0] tidx;
    logic cur;
    logic [7:0] edit;
    logic both;
    logic [2:0] bsy;
    logic blk;
    logic [TICK_W-1:0] tdiv;
    logic tick;
    logic [7:0] mon;
    logic [1:0] prv;
    logic [1:0] act;
    logic [1:0][15:0] pre;
    logic [1:0][4:0][7:0] stk;
    logic [1:0][7:0] scnt;
    logic [1:0] blocking_switchgroup;
    logic [3:0][15:0] opt;
    prmc_nv_t nv;
    logic unlock;
    logic [31:0] rdata;
    logic slverr;
    logic rel;
    prmc_disp_t disp;
  } prmc_st_t;
endpackage

// >>> logic/prmc_button.sv
// prmc_button: filter and press-length classifier for one push-button
// assumes an asynchronous pin and the system clock
`timescale 1ns/100ps
module prmc_button #(
  parameter int T_MID = prmc_pkg::STEP_FWD_CYC,
  parameter int T_HOLD = prmc_pkg::SCAN_START_CYC,
  parameter int T_REP = prmc_pkg::SCAN_REP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic btn_pin,
  input wire logic abort,
  output logic level,
  output logic ev_short,
  output logic ev_mid,
  output logic ev_hold,
  output logic ev_rep
);
  localparam int CW = prmc_pkg::BTN_CW;
  localparam logic [CW-1:0] MID_C = CW'(T_MID);
  localparam logic [CW-1:0] HOLD_C = CW'(T_HOLD - 1);
  localparam logic [CW-1:0] RELOAD_C = CW'(T_HOLD - T_REP);

  prmc_pkg::prmc_btn_t r;
  prmc_pkg::prmc_btn_t n;

  always_comb begin
    n = r;
    n.sh = 1'b0;
    n.md = 1'b0;
    n.hi = 1'b0;
    n.rp = 1'b0;
    n.sy = {r.sy[1:0], btn_pin};
    if (r.sy[2] == r.sy[1]) begin
      n.lvl = r.sy[1];
    end
    if (r.lvl && !n.lvl) begin
      // classified on release unless a hold or a combo already used it
      if (!r.ab && !r.p2 && !abort) begin
        n.sh = (r.cnt < MID_C);
        n.md = (r.cnt >= MID_C);
      end
      n.cnt = '0;
      n.p2 = 1'b0;
      n.ab = 1'b0;
    end else if (r.lvl) begin
      if (abort) begin
        n.ab = 1'b1;
      end
      if (r.cnt >= HOLD_C) begin
        n.cnt = RELOAD_C;
        n.p2 = 1'b1;
        n.rp = !r.ab && !abort;
        n.hi = !r.ab && !abort && !r.p2;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
    if (!reset_n) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign level = r.lvl;
  assign ev_short = r.sh;
  assign ev_mid = r.md;
  assign ev_hold = r.hi;
  assign ev_rep = r.rp;
endmodule

// >>> tb/prmc_panel.sv
// prmc_panel: operator push-button model for the recorder/menu block
// assumes the system clock; buttons are pressed by hierarchical task call
`timescale 1ns/100ps
module prmc_panel (
  input wire logic clk,
  output logic step_btn,
  output logic prog_btn
);
  initial begin
    step_btn = 1'b0;
    prog_btn = 1'b0;
  end

  // m[0] step, m[1] program; held n cycles, then a settling gap
  task automatic press(input logic [1:0] m, input int n);
    step_btn <= m[0];
    prog_btn <= m[1];
    repeat (n) @(posedge clk);
    step_btn <= 1'b0;
    prog_btn <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
endmodule

// >>> tb/testbench.sv
// testbench: APB and panel driven checks of the recorder/menu block
// assumes shortened press and tick parameters set at the instance
`timescale 1ns/100ps
module testbench;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic step_btn, prog_btn, blocking_input, serial_used, comm_active;
  logic [1:0] stage_start, stage_trip, stage_block;
  logic bank_sel, latch_release, setting_mode;
  logic [3:0] test_out;
  logic [1:0][15:0] op_time;
  prmc_pkg::prmc_nv_t nv_load, nv_cfg;
  prmc_pkg::prmc_disp_t disp;
  int failures = 0;
  int n_tests = 0;
  int lr_cnt = 0;
  int base;

  prmc_recorder_menu #(.STEP_FWD(50), .SCAN_START(200), .SCAN_REP(40), .PROG_SUB(100), .PROG_SET(400),
    .TICK(10)) u_prmc_recorder_menu (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_btn(step_btn), .prog_btn(prog_btn), .blocking_input(blocking_input), .stage_start(stage_start),
    .stage_trip(stage_trip), .serial_used(serial_used), .comm_active(comm_active), .nv_load(nv_load),
    .nv_cfg(nv_cfg), .stage_block(stage_block), .op_time(op_time), .bank_sel(bank_sel), .test_out(test_out),
    .latch_release(latch_release), .setting_mode(setting_mode), .disp(disp));
  prmc_panel u_prmc_panel (.clk(clk), .step_btn(step_btn), .prog_btn(prog_btn));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) if (latch_release === 1'b1) lr_cnt++;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next setup never reassigns psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d, rd, er);
    chk({31'h0, er}, {31'h0, xe});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, x);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #3_000_000;
    failures++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    blocking_input = 1'b1;
    serial_used = 1'b0;
    comm_active = 1'b1;
    stage_start = 2'h0;
    stage_trip = 2'h0;
    nv_load = '{addr: 8'h12, rate: 3'h2, pass: 8'h5C, bank: 1'b0};
    @(posedge clk);
    do_reset();
    chk({12'h0, nv_cfg}, {12'h0, 8'h00, nv_load.rate, nv_load.pass, nv_load.bank});
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0000_0064);
    apb(1'b0, 8'hFC, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    wr(8'h04, 32'h1, 1'b1);
    rdc(8'h04, 32'h0);
    wr(8'h1C, 32'h5C, 1'b0);
    wr(8'h04, 32'h1, 1'b0);
    repeat (4) @(posedge clk);
    chk({30'h0, stage_block}, 32'h1);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd & 32'h1, 32'h1);
    blocking_input <= 1'b0;
    repeat (6) @(posedge clk);
    chk({30'h0, stage_block}, 32'h0);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd & 32'h1, 32'h0);
    rdc(8'h4C, 32'h0);
    comm_active <= 1'b0;
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    base = rd;
    // setup edges 100 cycles apart: exactly ten ticks in between
    repeat (97) @(posedge clk);
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk(rd - base, 32'hA);
    comm_active <= 1'b1;
    wr(8'h18, 32'h0001_005A, 1'b0);
    rdc(8'h18, 32'h0001_0000);
    chk({31'h0, bank_sel}, 32'h1);
    wr(8'h10, 32'h0022, 1'b0);
    chk({16'h0, op_time[0]}, 32'h0022);
    serial_used <= 1'b1;
    wr(8'h18, 32'h0000_005A, 1'b0);
    rdc(8'h18, 32'h0000_005A);
    chk({31'h0, bank_sel}, 32'h0);
    $display("test config done");

    wr(8'h08, 32'h1, 1'b0);
    stage_start <= 2'h1;
    repeat (30) @(posedge clk);
    stage_trip <= 2'h1;
    repeat (2) @(posedge clk);
    stage_trip <= 2'h0;
    stage_start <= 2'h0;
    rdc(8'h20, 32'h64);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) rdc(8'h30, 32'h64);
      stage_start <= 2'h1;
      @(posedge clk);
      stage_start <= 2'h0;
      repeat (3) @(posedge clk);
    end
    rdc(8'h20, 32'h0);
    rdc(8'h30, 32'h0);
    rdc(8'h48, 32'h6);
    do_reset();
    rdc(8'h48, 32'h0);
    rdc(8'h2C, 32'h0);
    stage_start <= 2'h2;
    @(posedge clk);
    stage_start <= 2'h0;
    repeat (3) @(posedge clk);
    rdc(8'h48, 32'h100);
    base = lr_cnt;
    u_prmc_panel.press(2'h3, 20);
    rdc(8'h48, 32'h0);
    chk(lr_cnt - base, 32'h1);
    $display("test recorder done");

    u_prmc_panel.press(2'h1, 60);
    chk({28'h0, disp.adr}, 32'h2);
    u_prmc_panel.press(2'h1, 10);
    chk({28'h0, disp.adr}, 32'h1);
    for (int i = 0; i < 9; i++) u_prmc_panel.press(2'h1, 60);
    chk({28'h0, disp.adr}, 32'h0);
    u_prmc_panel.press(2'h2, 150);
    chk({28'h0, test_out}, 32'h1);
    u_prmc_panel.press(2'h1, 10);
    chk({28'h0, test_out}, 32'h2);
    u_prmc_panel.press(2'h2, 150);
    chk({28'h0, test_out}, 32'h0);
    u_prmc_panel.press(2'h1, 60);
    chk({28'h0, disp.adr}, 32'hA);
    u_prmc_panel.press(2'h2, 150);
    chk({24'h0, disp.val}, 32'h2);
    u_prmc_panel.press(2'h1, 10);
    chk({24'h0, disp.val}, 32'h12);
    u_prmc_panel.press(2'h2, 420);
    chk({31'h0, setting_mode}, 32'h1);
    u_prmc_panel.press(2'h1, 10);
    u_prmc_panel.press(2'h2, 150);
    u_prmc_panel.press(2'h1, 10);
    chk({24'h0, disp.val}, 32'h23);
    u_prmc_panel.press(2'h3, 20);
    chk({31'h0, setting_mode}, 32'h0);
    rdc(8'h18, 32'h0000_0223);
    u_prmc_panel.press(2'h2, 420);
    chk({31'h0, setting_mode}, 32'h1);
    u_prmc_panel.press(2'h2, 420);
    chk({31'h0, setting_mode}, 32'h0);
    u_prmc_panel.press(2'h1, 60);
    chk({27'h0, disp.on, disp.adr}, 32'hF);
    base = lr_cnt;
    u_prmc_panel.press(2'h2, 10);
    chk(lr_cnt - base, 32'h1);
    u_prmc_panel.press(2'h1, 10);
    chk({27'h0, disp.on, disp.adr}, 32'h11);
    u_prmc_panel.press(2'h2, 10);
    chk(lr_cnt - base, 32'h1);
    $display("test menu done");
    stop_test();
  end
endmodule
